//--- bench/pio_board_model.sv
// board-side model of the pins: sources, pull-ups and floating lines
`timescale 1ns/10ps
module pio_board_model (
	input wire logic CLK, // bus clock
	input wire logic [21:0] pin_o, // device output value
	input wire logic [21:0] pin_oe, // device drives the pin
	input wire logic [21:0] pin_pu, // device pull-up on
	input wire logic [21:0] ext_drv, // board source attached
	input wire logic [21:0] ext_val, // board source level
	output logic [21:0] pin_i // resolved pin level
);
	logic [21:0] flo = 22'h155555;
	// an undriven line wanders every cycle
	always @(posedge CLK) begin
		flo <= ~flo;
	end
	// device driver beats board source, which beats the weak pull-up
	always_comb begin
		for (int i = 0; i < 22; i++) begin
			if (pin_oe[i]) begin
				pin_i[i] = pin_o[i];
			end else if (ext_drv[i]) begin
				pin_i[i] = ext_val[i];
			end else begin
				pin_i[i] = pin_pu[i] ? 1'b1 : flo[i];
			end
		end
	end
endmodule

//--- bench/tb_pio_port.sv
// self-checking bench for the parallel port pin control
`timescale 1ns/10ps
module tb_pio_port;
	localparam logic [21:0] ALL = 22'h3fffff;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic [21:0] dwd, dwe, rwd, rwe, pwd, pwe, swd, swe, hwd, hwe, den, doe, dou, aen, xdr, xv;
	logic [21:0] ddr, ddir, dpl, dsl, dhd, dgi, prs, po, poe, pie, ppu, psl, phd, pin;
	logic [21:0] rd, rdir, rpl, rsl, rhd;
	int errors = 0;
	int checks_done = 0;
	int seed = 32'hb649;
	always #10 CLK = ~CLK;
	pio_port i_pio_port (.CLK(CLK), .RST_N(RST_N), .DATA_WDATA(dwd), .DATA_WE(dwe),
		.DIR_WDATA(rwd), .DIR_WE(rwe), .PULL_WDATA(pwd), .PULL_WE(pwe), .SLEW_WDATA(swd),
		.SLEW_WE(swe), .DRIVE_WDATA(hwd), .DRIVE_WE(hwe), .DIG_EN(den), .DIG_OE(doe),
		.DIG_OUT(dou), .ANA_EN(aen), .PIN_I(pin), .DATA_RDATA(ddr), .DIR_RDATA(ddir),
		.PULL_RDATA(dpl), .SLEW_RDATA(dsl), .DRIVE_RDATA(dhd), .DIG_IN(dgi),
		.PERIPH_RESET(prs), .PIN_O(po), .PIN_OE(poe), .PIN_IE(pie), .PIN_PU(ppu),
		.PIN_SLEW(psl), .PIN_HD(phd));
	pio_board_model i_pio_board_model (.CLK(CLK), .pin_o(po), .pin_oe(poe), .pin_pu(ppu),
		.ext_drv(xdr), .ext_val(xv), .pin_i(pin));
	function automatic logic [21:0] rnd;
		rnd = 22'($random(seed));
	endfunction
	task tick(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	// compare only the bits that are known
	task chk(input logic [21:0] got, input logic [21:0] exp, input logic [21:0] m);
		checks_done++;
		if (((got ^ exp) & m) !== 22'h0) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// data first, other controls one cycle later, shadows follow the strobes
	task write_all;
		dwd = rnd();
		dwe = rnd();
		rd = (rd & ~dwe) | (dwd & dwe);
		tick(1);
		dwe = 22'h0;
		rwd = rnd(); rwe = rnd(); pwd = rnd(); pwe = rnd();
		swd = rnd(); swe = rnd(); hwd = rnd(); hwe = rnd();
		rdir = (rdir & ~rwe) | (rwd & rwe);
		rpl = (rpl & ~pwe) | (pwd & pwe);
		rsl = (rsl & ~swe) | (swd & swe);
		rhd = (rhd & ~hwe) | (hwd & hwe);
		tick(1);
		{rwe, pwe, swe, hwe} = 88'h0;
	endtask
	// expected pin controls and reads from the shadows
	task check_all;
		logic [21:0] oe, o, ie, pu, p, k;
		ie = ~aen;
		oe = ie & ((den & doe) | (~den & rdir));
		o = (den & dou) | (~den & rd);
		pu = rpl & ~oe & ie;
		p = (oe & o) | (~oe & xdr & xv) | (~oe & ~xdr & pu);
		k = oe | xdr | pu;
		chk(poe, oe, ALL);
		chk(po, o, oe);
		chk(pie, ie, ALL);
		chk(ppu, pu, ALL);
		chk(psl, rsl & oe, ALL);
		chk(phd, rhd & oe, ALL);
		chk(ddr, (rdir & rd) | (~rdir & ie & p), rdir | ~ie | k);
		chk(dgi, ie & p, ~ie | k);
		chk({ddir, dpl, dsl, dhd}, {rdir, rpl, rsl, rhd}, {4{ALL}});
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// reset with functions requested, then random mixes with corners first
	initial begin
		{dwd, dwe, rwd, rwe, pwd, pwe, swd, swe, hwd, hwe} = 220'h0;
		{rd, rdir, rpl, rsl, rhd, dou, aen, xv} = 176'h0;
		den = ALL;
		doe = ALL;
		xdr = ALL;
		tick(5);
		chk(poe, 22'h0, ALL);
		chk(prs, ALL, ALL);
		chk({ddir, dpl, dsl, dhd, ppu}, 110'h0, {5{ALL}});
		$display("test reset_defaults done");
		RST_N = 1'b1;
		for (int i = 0; i < 60; i++) begin
			write_all;
			den = rnd(); doe = rnd(); dou = rnd(); xdr = rnd(); xv = rnd();
			aen = rnd() & rnd();
			if (i < 2) begin
				den = ALL;
				aen = (i == 0) ? ALL : 22'h0;
			end
			tick(8);
			check_all;
		end
		$display("test random_mix done");
		give_verdict;
	end
endmodule

//--- verilog/pio_pin_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module pio_pin_sync (
	input wire logic CLK, // bus clock
	input wire logic RST_N, // synchronous reset, active low
	input wire logic pin_in, // raw pin level
	output logic level // filtered level
);
	logic s1, s2, s3;
	logic next_s1, next_s2, next_s3, next_level;

	// shift chain; level follows once stages two and three agree
	always_comb begin
		next_s1 = pin_in;
		next_s2 = s1;
		next_s3 = s2;
		next_level = (s2 == s3) ? s3 : level;
	end

	// register stage
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			level <= 1'b0;
		end else begin
			s1 <= next_s1;
			s2 <= next_s2;
			s3 <= next_s3;
			level <= next_level;
		end
	end
endmodule

//--- verilog/pio_pkg.sv
// constants shared by the parallel port block
package pio_pkg;
	localparam int NUM_PINS = 22;
	localparam int SYNC_STAGES = 3;
	localparam logic [NUM_PINS-1:0] DIR_RESET = 22'h000000;
	localparam logic [NUM_PINS-1:0] CTRL_RESET = 22'h000000;
	localparam logic [NUM_PINS-1:0] DATA_RESET = 22'h000000;
	localparam logic [NUM_PINS-1:0] INPUT_ONLY_NONE = 22'h000000;
endpackage

//--- verilog/pio_port.sv
// parallel io port pin control for all 22 pins
// Operation
// - one port, 22 pins, data and direction each
// - reset clears peripheral enables and directions
// - reset clears slew, drive and pull-up bits
// - enabled peripheral overrides general-purpose io
// - direction enables driver and selects read source
// - input buffer on unless analog or output-only
// - digital function drives; direction still picks read
// - analog function disables input and output buffers
// - input read with buffer off returns zero
// - analog wins over digital alternate function
// - pin controls independent of data and direction
// - pull-up bit switches pull-up on
// - pull-up off when pin drives output
// - pull-up off under analog control
// - slew limit only matters for outputs
// - high-drive bit raises output drive strength
`timescale 1ns/10ps
module pio_port (
	input wire logic CLK, // bus clock, 50 MHz
	input wire logic RST_N, // synchronous reset, active low
	input wire logic [21:0] DATA_WDATA, // data to write into output latch
	input wire logic [21:0] DATA_WE, // per-bit write strobe for latch
	input wire logic [21:0] DIR_WDATA, // direction write data
	input wire logic [21:0] DIR_WE, // per-bit direction write strobe
	input wire logic [21:0] PULL_WDATA, // pull-up enable write data
	input wire logic [21:0] PULL_WE, // per-bit pull-up write strobe
	input wire logic [21:0] SLEW_WDATA, // slew-limit write data
	input wire logic [21:0] SLEW_WE, // per-bit slew-limit write strobe
	input wire logic [21:0] DRIVE_WDATA, // high-drive write data
	input wire logic [21:0] DRIVE_WE, // per-bit high-drive write strobe
	input wire logic [21:0] DIG_EN, // shared digital function enabled
	input wire logic [21:0] DIG_OE, // digital function output enable
	input wire logic [21:0] DIG_OUT, // digital function output data
	input wire logic [21:0] ANA_EN, // shared analog function enabled
	input wire logic [21:0] PIN_I, // pin input levels
	output logic [21:0] DATA_RDATA, // port data read value
	output logic [21:0] DIR_RDATA, // direction register value
	output logic [21:0] PULL_RDATA, // pull-up enable register value
	output logic [21:0] SLEW_RDATA, // slew-limit register value
	output logic [21:0] DRIVE_RDATA, // high-drive register value
	output logic [21:0] DIG_IN, // pin level seen by digital function
	output logic [21:0] PERIPH_RESET, // high while shared functions held off
	output logic [21:0] PIN_O, // pin output value
	output logic [21:0] PIN_OE, // pin output enable, high drives
	output logic [21:0] PIN_IE, // pin input buffer enable
	output logic [21:0] PIN_PU, // pull-up device on
	output logic [21:0] PIN_SLEW, // slew limiting on
	output logic [21:0] PIN_HD // high drive on
);
	localparam int N = pio_pkg::NUM_PINS;

	logic [N-1:0] latch, dir, pull, slew, drive;
	logic [N-1:0] next_latch, next_dir, next_pull, next_slew, next_drive;
	logic [N-1:0] pin_sync;
	logic [N-1:0] ibuf_en, drv_en, drv_val, analog, digital;
	logic [N-1:0] next_rdata, next_pin_o, next_oe, next_ie, next_pu, next_sl, next_hd;
	logic in_reset;

	// per-pin input synchronisers
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gen_sync
			pio_pin_sync u_sync (
				.CLK(CLK),
				.RST_N(RST_N),
				.pin_in(PIN_I[g]),
				.level(pin_sync[g])
			);
		end
	endgenerate

	// register next values, each written bit by bit
	always_comb begin
		next_latch = (latch & ~DATA_WE) | (DATA_WDATA & DATA_WE);
		next_dir = (dir & ~DIR_WE) | (DIR_WDATA & DIR_WE);
		next_pull = (pull & ~PULL_WE) | (PULL_WDATA & PULL_WE);
		next_slew = (slew & ~SLEW_WE) | (SLEW_WDATA & SLEW_WE);
		next_drive = (drive & ~DRIVE_WE) | (DRIVE_WDATA & DRIVE_WE);
	end

	// register file, cleared on reset
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			latch <= pio_pkg::DATA_RESET;
			dir <= pio_pkg::DIR_RESET;
			pull <= pio_pkg::CTRL_RESET;
			slew <= pio_pkg::CTRL_RESET;
			drive <= pio_pkg::CTRL_RESET;
			in_reset <= 1'b1;
		end else begin
			latch <= next_latch;
			dir <= next_dir;
			pull <= next_pull;
			slew <= next_slew;
			drive <= next_drive;
			in_reset <= 1'b0;
		end
	end

	// ownership: analog over digital over port logic; shared off in reset
	always_comb begin
		analog = ANA_EN & {N{~in_reset}};
		digital = DIG_EN & ~ANA_EN & {N{~in_reset}};
		drv_en = '0;
		for (int i = 0; i < N; i++) begin
			if (analog[i]) begin
				drv_en[i] = 1'b0;
			end else if (digital[i]) begin
				drv_en[i] = DIG_OE[i];
			end else begin
				drv_en[i] = dir[i];
			end
		end
		drv_val = (digital & DIG_OUT) | (~digital & latch);
		ibuf_en = ~analog & ~pio_pkg::INPUT_ONLY_NONE;
	end

	// pin-side next values and read mux
	always_comb begin
		next_rdata = (dir & latch) | (~dir & ibuf_en & pin_sync);
		next_pin_o = drv_val;
		next_oe = drv_en;
		next_ie = ibuf_en;
		next_pu = pull & ~drv_en & ~analog;
		next_sl = slew & drv_en;
		next_hd = drive & drv_en;
	end

	// output registers
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			DATA_RDATA <= '0;
			PIN_O <= '0;
			PIN_OE <= '0;
			PIN_IE <= '1;
			PIN_PU <= '0;
			PIN_SLEW <= '0;
			PIN_HD <= '0;
		end else begin
			DATA_RDATA <= next_rdata;
			PIN_O <= next_pin_o;
			PIN_OE <= next_oe;
			PIN_IE <= next_ie;
			PIN_PU <= next_pu;
			PIN_SLEW <= next_sl;
			PIN_HD <= next_hd;
		end
	end

	// direct register views and the gated digital input
	assign DIR_RDATA = dir;
	assign PULL_RDATA = pull;
	assign SLEW_RDATA = slew;
	assign DRIVE_RDATA = drive;
	assign DIG_IN = pin_sync & ibuf_en;
	assign PERIPH_RESET = {N{in_reset}};

	// analog pin never drives
	a_analog_no_drive: assert property (@(posedge CLK) disable iff (!RST_N)
		$past(ANA_EN[0]) && !$past(in_reset) |-> !PIN_OE[0] && !PIN_IE[0])
		else $error("analog pin driven");
	// pull-up off for driven pin
	a_pullup_output_off: assert property (@(posedge CLK) disable iff (!RST_N)
		(PIN_OE & PIN_PU) == '0)
		else $error("pull-up on while driving");
	// read zero when input buffer off
	a_read_zero_off: assert property (@(posedge CLK) disable iff (!RST_N)
		!$past(dir[0]) && !$past(ibuf_en[0]) |-> !DATA_RDATA[0])
		else $error("nonzero read with buffer off");
	// output read returns latch
	a_read_latch: assert property (@(posedge CLK) disable iff (!RST_N)
		$past(dir[0]) |-> DATA_RDATA[0] == $past(latch[0]))
		else $error("output read not latch");
	// digital function drives its own enable
	a_digital_owns: assert property (@(posedge CLK) disable iff (!RST_N)
		$past(digital[1]) |-> PIN_OE[1] == $past(DIG_OE[1]) && PIN_O[1] == $past(DIG_OUT[1]))
		else $error("digital function lost pin");
	// slew and drive only on outputs
	a_slew_output_only: assert property (@(posedge CLK) disable iff (!RST_N)
		((PIN_SLEW | PIN_HD) & ~PIN_OE) == '0)
		else $error("slew or drive on input");
	// reset leaves pins as inputs
	a_reset_inputs: assert property (@(posedge CLK)
		!RST_N |=> dir == '0 && pull == '0 && slew == '0 && drive == '0)
		else $error("reset values wrong");
	// pull-up follows bit on idle input
	a_pullup_follows: assert property (@(posedge CLK) disable iff (!RST_N)
		$past(pull[2]) && !$past(drv_en[2]) && !$past(analog[2]) |-> PIN_PU[2])
		else $error("pull-up not on");

	// per-pin checks of ownership, reads and pin controls
	genvar k;
	generate
		for (k = 0; k < N; k++) begin : gen_pin_chk
			// analog pin releases both buffers
			a_pin_analog_off: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) && $past(analog[k]) |-> !PIN_OE[k] && !PIN_IE[k])
				else $error("analog pin buffers on");

			// analog pin has no pull-up
			a_pin_analog_pull: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) && $past(analog[k]) |-> !PIN_PU[k])
				else $error("pull-up on under analog");

			// analog beats digital on one pin
			a_pin_analog_wins: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) && !$past(in_reset) && $past(ANA_EN[k]) && $past(DIG_EN[k])
				|-> !PIN_OE[k] && !PIN_IE[k])
				else $error("digital beat analog");

			// port logic drive follows direction
			a_pin_port_drive: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) && !$past(analog[k]) && !$past(digital[k])
				|-> PIN_OE[k] == $past(dir[k]))
				else $error("port drive not direction");

			// port logic value is the latch
			a_pin_port_value: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) && !$past(digital[k]) |-> PIN_O[k] == $past(latch[k]))
				else $error("port value not latch");

			// digital function owns the enable
			a_pin_digital_drive: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) && $past(digital[k]) |-> PIN_OE[k] == $past(DIG_OE[k]))
				else $error("digital enable lost");

			// digital function owns the value
			a_pin_digital_value: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) && $past(digital[k]) |-> PIN_O[k] == $past(DIG_OUT[k]))
				else $error("digital value lost");

			// output read gives the latch
			a_pin_read_latch: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) && $past(dir[k]) |-> DATA_RDATA[k] == $past(latch[k]))
				else $error("output read not latch");

			// input read gives the synced pin
			a_pin_read_input: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) && !$past(dir[k]) && $past(ibuf_en[k])
				|-> DATA_RDATA[k] == $past(pin_sync[k]))
				else $error("input read not pin");

			// input read with buffer off is zero
			a_pin_read_zero: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) && !$past(dir[k]) && !$past(ibuf_en[k]) |-> !DATA_RDATA[k])
				else $error("read not zero");

			// input buffer stays on otherwise
			a_pin_ibuf_on: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) && !$past(analog[k]) |-> PIN_IE[k])
				else $error("input buffer off");

			// pull-up bit switches pull-up on
			a_pin_pull_on: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) && $past(pull[k]) && !$past(drv_en[k]) && !$past(analog[k])
				|-> PIN_PU[k])
				else $error("pull-up not on");

			// driven pin has no pull-up
			a_pin_pull_drive: assert property (@(posedge CLK) disable iff (!RST_N)
				PIN_OE[k] |-> !PIN_PU[k])
				else $error("pull-up on driven pin");

			// slew bit acts on outputs
			a_pin_slew_on: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) && $past(slew[k]) && $past(drv_en[k]) |-> PIN_SLEW[k])
				else $error("slew limit not on");

			// slew bit idle on inputs
			a_pin_slew_input: assert property (@(posedge CLK) disable iff (!RST_N)
				!PIN_OE[k] |-> !PIN_SLEW[k])
				else $error("slew limit on input");

			// high-drive bit acts on outputs
			a_pin_drive_on: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) && $past(drive[k]) && $past(drv_en[k]) |-> PIN_HD[k])
				else $error("high drive not on");

			// high drive idle on inputs
			a_pin_drive_input: assert property (@(posedge CLK) disable iff (!RST_N)
				!PIN_OE[k] |-> !PIN_HD[k])
				else $error("high drive on input");

			// direction write lands
			a_pin_dir_write: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) && $past(DIR_WE[k]) |-> dir[k] == $past(DIR_WDATA[k]))
				else $error("direction write lost");

			// data write lands
			a_pin_data_write: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) && $past(DATA_WE[k]) |-> latch[k] == $past(DATA_WDATA[k]))
				else $error("data write lost");

			// pull-up write lands
			a_pin_ctrl_write: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) && $past(PULL_WE[k]) |-> pull[k] == $past(PULL_WDATA[k]))
				else $error("pull-up write lost");

			// slew and high-drive bits keep value without strobe
			a_pin_ctrl_hold: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) && !$past(SLEW_WE[k]) && !$past(DRIVE_WE[k])
				|-> slew[k] == $past(slew[k]) && drive[k] == $past(drive[k]))
				else $error("control changed unasked");

			// shared functions held off in reset
			a_pin_shared_held: assert property (@(posedge CLK) disable iff (!RST_N)
				in_reset |-> !analog[k] && !digital[k] && PERIPH_RESET[k])
				else $error("shared function not held");

			// digital input gated by buffer
			a_pin_dig_in_off: assert property (@(posedge CLK) disable iff (!RST_N)
				!ibuf_en[k] |-> !DIG_IN[k])
				else $error("digital input not gated");
		end
	endgenerate
endmodule
